// ==== core/spe_pkg.sv ====
package spe_pkg;
  localparam int KEY_BITS = 32;
  localparam int WORD_BITS = 14;
  localparam int FIFO_DEPTH = 32;
  // Key value is arbitrary.
  localparam logic [31:0] ENTRY_KEY_DEFAULT = 32'h5A3C_96E1;
  localparam logic LVP_RESET = 1'b1;
  localparam logic [1:0] SYNC_RESET = 2'h0;
  localparam logic [1:0] MASTER_CLEAR_PIN_SYNC_RESET = 2'h3;
  localparam logic [5:0] KEYCNT_RESET = 6'h00;
  localparam logic [4:0] BITCNT_RESET = 5'h00;
  typedef enum logic [2:0] {
    SPE_NORMAL = 3'h0,
    SPE_KEY = 3'h1,
    SPE_LVMODE = 3'h3,
    SPE_HVMODE = 3'h2,
    SPE_FAIL = 3'h6
  } spe_state_t;
endpackage

// ==== core/spe_entry.sv ====
`timescale 1ns/100ps

module spe_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
  } spe_fifo_t;
  spe_fifo_t s_q, s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] fill;

  assign fill = s_q.wrPtr - s_q.rdPtr;
  assign inReady = fill != (AW+1)'(DEPTH);
  assign outValid = fill != '0;
  assign outData = mem[s_q.rdPtr[AW-1:0]];

  always_comb begin
    s_d = s_q;
    if (inValid && inReady) begin
      s_d.wrPtr = s_q.wrPtr + 1'b1;
    end
    if (outValid && outReady) begin
      s_d.rdPtr = s_q.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clkEn && inValid && inReady) begin
      mem[s_q.wrPtr[AW-1:0]] <= inData;
    end
  end
endmodule

// How it works
// R1 - Clock, data low then high level enters
// R2 - Key entry only while allow bit set
// R3 - Allow bit clears only in high-voltage mode
// R4 - Programmer pulls clear low, clocks 32-bit key
// R5 - Clear held low keeps low-voltage mode, release exits
// R6 - Allow bit forces clear-pin reset on
// R7 - Clock is input, data pin bidirectional
// R8 - Program mode streams words to memories
// R9 - Key compared fully, mismatch stays in reset
module spe_entry
  import spe_pkg::*;
#(
  parameter logic [31:0] ENTRY_KEY = spe_pkg::ENTRY_KEY_DEFAULT,
  parameter int DATA_W = spe_pkg::WORD_BITS,
  parameter int DEPTH = spe_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  // Programming pins
  input wire logic progSerialClock,
  input wire logic progSerialDataIn,
  output logic progSerialDataOut,
  output logic progSerialDataOe_n,
  input wire logic masterClearPin,
  input wire logic highProgrammingLevel,
  // Configuration
  input wire logic lowVoltageAllowInit,
  input wire logic lowVoltageAllowClearReq,
  input wire logic mclrEnableSetting,
  output logic lowVoltageEntryAllow,
  output logic mclrResetEnable,
  output logic programMode,
  // Memory write stream
  output logic wrValid,
  input wire logic wrReady,
  output logic [DATA_W-1:0] wrData
);
  import spe_pkg::*;

  typedef struct packed {
    spe_state_t st;
    logic [1:0] clkSync;
    logic [1:0] datSync;
    logic [1:0] mclrSync;
    logic [1:0] hvSync;
    logic clkPrev;
    logic [5:0] keyCnt;
    logic [KEY_BITS-1:0] keySh;
    logic [4:0] bitCnt;
    logic [DATA_W-1:0] word;
    logic push;
    logic busy;
    logic low_voltage_entry_allow;
    logic loaded;
  } spe_reg_t;

  spe_reg_t s_q, s_d;
  logic clkRise, mclrLow, hvHigh, fifoReady;

  assign clkRise = s_q.clkSync[1] && !s_q.clkPrev;
  assign mclrLow = !s_q.mclrSync[1];
  assign hvHigh = s_q.hvSync[1];
  assign programMode = s_q.st == SPE_LVMODE || s_q.st == SPE_HVMODE;
  assign lowVoltageEntryAllow = s_q.low_voltage_entry_allow;
  assign mclrResetEnable = s_q.low_voltage_entry_allow || mclrEnableSetting; // R6
  assign progSerialDataOut = 1'b0;
  // Busy is shown by pulling data low, since the programmer cannot be stalled otherwise.
  assign progSerialDataOe_n = !(programMode && s_q.busy); // R7

  always_comb begin
    s_d = s_q;
    s_d.clkSync = {s_q.clkSync[0], progSerialClock};
    s_d.datSync = {s_q.datSync[0], progSerialDataIn};
    s_d.mclrSync = {s_q.mclrSync[0], masterClearPin};
    s_d.hvSync = {s_q.hvSync[0], highProgrammingLevel};
    s_d.clkPrev = s_q.clkSync[1];
    s_d.push = 1'b0;
    s_d.loaded = 1'b1;
    // The stored allow bit is loaded after release, never under the reset itself.
    if (!s_q.loaded) begin
      s_d.low_voltage_entry_allow = lowVoltageAllowInit; // R2
    end
    if (fifoReady) begin
      s_d.busy = 1'b0;
    end
    case (s_q.st)
      SPE_NORMAL: begin
        s_d.keyCnt = KEYCNT_RESET;
        if (hvHigh && !s_q.clkSync[1] && !s_q.datSync[1]) begin
          s_d.st = SPE_HVMODE; // R1
        end else if (mclrLow && s_q.low_voltage_entry_allow) begin
          s_d.st = SPE_KEY; // R2
        end
      end
      SPE_KEY: begin
        if (!mclrLow) begin
          s_d.st = SPE_NORMAL;
        end else if (s_q.keyCnt == 6'(KEY_BITS)) begin
          s_d.st = s_q.keySh == ENTRY_KEY ? SPE_LVMODE : SPE_FAIL; // R9
        end else if (clkRise) begin
          s_d.keySh = {s_q.keySh[KEY_BITS-2:0], s_q.datSync[1]}; // R9
          s_d.keyCnt = s_q.keyCnt + 1'b1;
        end
      end
      SPE_LVMODE, SPE_HVMODE: begin
        if ((s_q.st == SPE_LVMODE && !mclrLow) || (s_q.st == SPE_HVMODE && !hvHigh)) begin
          s_d.st = SPE_NORMAL; // R5
          s_d.bitCnt = BITCNT_RESET;
        end else if (clkRise) begin
          s_d.word = {s_q.datSync[1], s_q.word[DATA_W-1:1]}; // R8
          if (s_q.bitCnt == 5'(DATA_W - 1)) begin
            s_d.bitCnt = BITCNT_RESET;
            s_d.push = 1'b1;
            s_d.busy = !fifoReady;
          end else begin
            s_d.bitCnt = s_q.bitCnt + 1'b1;
          end
        end
        if (s_q.st == SPE_HVMODE && lowVoltageAllowClearReq) begin
          s_d.low_voltage_entry_allow = 1'b0; // R3
        end
      end
      SPE_FAIL: begin
        if (!mclrLow) begin
          s_d.st = SPE_NORMAL; // R9
        end
      end
      default: begin
        s_d.st = SPE_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= SPE_NORMAL;
      s_q.low_voltage_entry_allow <= LVP_RESET;
      s_q.mclrSync <= MASTER_CLEAR_PIN_SYNC_RESET;
      s_q.keyCnt <= KEYCNT_RESET;
      s_q.bitCnt <= BITCNT_RESET;
      s_q.clkSync <= SYNC_RESET;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  spe_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .clkEn(clkEn),
    .inValid(s_q.push),
    .inReady(fifoReady),
    .inData(s_q.word),
    .outValid(wrValid),
    .outReady(wrReady),
    .outData(wrData)
  );

  AST_HV_ENTRY: assert property (@(posedge clk_sys) disable iff (rst) // R1
    clkEn && s_q.st == SPE_NORMAL && hvHigh && !s_q.clkSync[1] && !s_q.datSync[1]
    |=> s_q.st == SPE_HVMODE)
    else $error("High-voltage entry not taken.");
  AST_LV_GATED: assert property (@(posedge clk_sys) disable iff (rst) // R2
    $rose(s_q.st == SPE_KEY) |-> $past(s_q.low_voltage_entry_allow))
    else $error("Key phase entered without allow bit.");
  AST_LVP_CLEAR: assert property (@(posedge clk_sys) disable iff (rst) // R3
    $fell(s_q.low_voltage_entry_allow) && $past(s_q.loaded) |-> $past(s_q.st) == SPE_HVMODE)
    else $error("Allow bit cleared outside high-voltage mode.");
  AST_MASTER_CLEAR_PIN_FORCED: assert property (@(posedge clk_sys) disable iff (rst) // R6
    s_q.low_voltage_entry_allow |-> mclrResetEnable)
    else $error("Clear reset not forced while allow bit set.");
  AST_DATA_DIR: assert property (@(posedge clk_sys) disable iff (rst) // R7
    !programMode |-> progSerialDataOe_n)
    else $error("Data pin driven outside program mode.");
  AST_PUSH_MODE: assert property (@(posedge clk_sys) disable iff (rst) // R8
    s_q.push |-> $past(programMode))
    else $error("Word pushed outside program mode.");
  AST_KEY_MISMATCH: assert property (@(posedge clk_sys) disable iff (rst) // R9
    clkEn && s_q.st == SPE_KEY && mclrLow && s_q.keyCnt == 6'(KEY_BITS) && s_q.keySh != ENTRY_KEY
    |=> s_q.st == SPE_FAIL ##0 !programMode)
    else $error("Wrong key did not lead to failure state.");
  AST_LV_EXIT: assert property (@(posedge clk_sys) disable iff (rst) // R5
    clkEn && s_q.st == SPE_LVMODE && !mclrLow |=> s_q.st == SPE_NORMAL)
    else $error("Low-voltage mode not left on clear release.");

  COV_HV: cover property (@(posedge clk_sys) disable iff (rst) s_q.st == SPE_HVMODE);
  COV_LV: cover property (@(posedge clk_sys) disable iff (rst) s_q.st == SPE_LVMODE);
  COV_FAIL: cover property (@(posedge clk_sys) disable iff (rst) s_q.st == SPE_FAIL);
  COV_WORD: cover property (@(posedge clk_sys) disable iff (rst) wrValid && wrReady);
endmodule

// ==== verif/spe_prog_model.sv ====
`timescale 1ns/100ps

// Programmer stand-in; its serial clock stands still between frames.
module spe_prog_model (
  // Pins toward the device
  output logic sck,
  output logic sdat,
  output logic clearPin,
  output logic hvLevel
);
  initial begin
    sck = 1'b0;
    sdat = 1'b0;
    clearPin = 1'b1;
    hvLevel = 1'b0;
  end

  // Clock and data are held low whenever the pins change, so a high level enters cleanly.
  task automatic setPins(input logic c, input logic h);
    clearPin <= c;
    hvLevel <= h;
    sdat <= 1'b0;
  endtask

  // Data changes only while the clock is low; a released line shows the inverse of its last bit.
  task automatic sendBits(input logic [31:0] v, input int n, input bit msb);
    for (int k = 0; k < n; k++) begin
      sdat = v[msb ? n - 1 - k : k];
      #24 sck = 1'b1;
      #24 sck = 1'b0;
    end
    sdat = ~sdat;
  endtask
endmodule

// ==== verif/tb_spe_entry.sv ====
`timescale 1ns/100ps

module tb_spe_entry;
  import spe_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wrReady = 1'b0;
  logic clearReq = 1'b0;
  logic clrSet = 1'b0;
  logic allowInit = 1'b1;
  logic sck, sdat, clearPin, hvLevel, dOut, dOe_n, allow, clrRstEn, progMode, wrValid, dataLine;
  logic [WORD_BITS-1:0] wrData;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;

  always #2.5 clk_sys = ~clk_sys;

  // The device pulls the shared data line low while busy.
  assign dataLine = dOe_n ? sdat : dOut;

  spe_entry spe_entry_i (.clk_sys(clk_sys), .rst(rst), .clkEn(1'b1), .progSerialClock(sck),
    .progSerialDataIn(dataLine), .progSerialDataOut(dOut), .progSerialDataOe_n(dOe_n),
    .masterClearPin(clearPin), .highProgrammingLevel(hvLevel), .lowVoltageAllowInit(allowInit),
    .lowVoltageAllowClearReq(clearReq), .mclrEnableSetting(clrSet), .lowVoltageEntryAllow(allow),
    .mclrResetEnable(clrRstEn), .programMode(progMode), .wrValid(wrValid), .wrReady(wrReady),
    .wrData(wrData));
  spe_prog_model spe_prog_model_i (.sck(sck), .sdat(sdat), .clearPin(clearPin), .hvLevel(hvLevel));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Pin syncs need a few cycles, so the key and release steps wait six before looking.
  task automatic tKey(input logic [31:0] key, input logic expMode);
    @(posedge clk_sys);
    spe_prog_model_i.setPins(1'b0, 1'b0);
    settle(6);
    spe_prog_model_i.sendBits(key, KEY_BITS, 1'b1);
    settle(6);
    chk("programMode", progMode, expMode);
  endtask

  task automatic tRelease;
    @(posedge clk_sys);
    spe_prog_model_i.setPins(1'b1, 1'b0);
    settle(6);
    chk("programMode", progMode, 1'b0);
  endtask

  task automatic tReset;
    settle(4);
    chk("programMode", progMode, 1'b0);
    chk("allow", allow, 1'b1);
    chk("clrRstEn", clrRstEn, 1'b1);
    @(posedge clk_sys);
    clearReq <= 1'b1;
    settle(4);
    chk("allow", allow, 1'b1);
    @(posedge clk_sys);
    clearReq <= 1'b0;
  endtask

  // A second reset reloads the allow bit from its stored value.
  task automatic tReinit;
    @(posedge clk_sys);
    rst <= 1'b1;
    allowInit <= 1'b0;
    clrSet <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    settle(4);
    chk("allow", allow, 1'b0);
    chk("clrRstEn", clrRstEn, 1'b0);
    chk("programMode", progMode, 1'b0);
  endtask

  // Fill past the depth with the sink stalled, then drain to empty.
  task automatic tStream;
    int n;
    for (int i = 0; i <= FIFO_DEPTH; i++) spe_prog_model_i.sendBits(i * 5 + 3, WORD_BITS, 1'b0);
    settle(6);
    chk("busy", dOe_n, 1'b0);
    chk("dataOut", dOut, 1'b0);
    @(posedge clk_sys);
    wrReady <= 1'b1;
    n = 0;
    repeat (80) begin
      @(negedge clk_sys);
      if (wrValid === 1'b1) begin
        chk("wrData", wrData, n * 5 + 3);
        n++;
      end
    end
    chk("words", n, FIFO_DEPTH);
    chk("busy", dOe_n, 1'b1);
  endtask

  task automatic tHv;
    @(posedge clk_sys);
    spe_prog_model_i.setPins(1'b1, 1'b1);
    settle(6);
    chk("programMode", progMode, 1'b1);
    @(posedge clk_sys);
    clearReq <= 1'b1;
    settle(4);
    chk("allow", allow, 1'b0);
    chk("clrRstEn", clrRstEn, 1'b0);
    @(posedge clk_sys);
    clearReq <= 1'b0;
    clrSet <= 1'b1;
    settle(2);
    chk("clrRstEn", clrRstEn, 1'b1);
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    tReset();
    tKey(ENTRY_KEY_DEFAULT ^ 32'h0000_0001, 1'b0);
    tRelease();
    tKey(ENTRY_KEY_DEFAULT, 1'b1);
    tStream();
    tRelease();
    tHv();
    tRelease();
    tKey(ENTRY_KEY_DEFAULT, 1'b0);
    tRelease();
    tReinit();
    tKey(ENTRY_KEY_DEFAULT, 1'b0);
    results();
  end
endmodule
